// File: hdl/mide_pkg.sv
// Constants shared by the instruction decode and execute core and its ALU.
// Assumes a 14-bit program word and a 7-bit direct data address.
package mide_pkg;

   // Widths and sizes
   localparam int INSTR_W = 14;
   localparam int ADDR_W  = 7;
   localparam int PC_W    = 13;
   localparam int DATA_W  = 8;
   localparam int TGT_W   = 11;
   localparam int STACK_D = 8;
   localparam int BUS_W   = 16;
   localparam int OSC_PER_CYCLE = 4;

   // Opcode group prefixes in bits 13:12
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT  = 2'h1;
   localparam logic [1:0] GRP_CTRL = 2'h2;
   localparam logic [1:0] GRP_LIT  = 2'h3;

   // Byte-oriented operation codes in bits 11:8
   localparam logic [3:0] OP_MOVWF = 4'h0;
   localparam logic [3:0] OP_CLR   = 4'h1;
   localparam logic [3:0] OP_SUB   = 4'h2;
   localparam logic [3:0] OP_DEC   = 4'h3;
   localparam logic [3:0] OP_OR    = 4'h4;
   localparam logic [3:0] OP_AND   = 4'h5;
   localparam logic [3:0] OP_XOR   = 4'h6;
   localparam logic [3:0] OP_ADD   = 4'h7;
   localparam logic [3:0] OP_MOV   = 4'h8;
   localparam logic [3:0] OP_COM   = 4'h9;
   localparam logic [3:0] OP_INC   = 4'hA;
   localparam logic [3:0] OP_DECSZ = 4'hB;
   localparam logic [3:0] OP_RRC   = 4'hC;
   localparam logic [3:0] OP_RLC   = 4'hD;
   localparam logic [3:0] OP_SWAP  = 4'hE;
   localparam logic [3:0] OP_INCSZ = 4'hF;

   // Literal group codes in bits 11:8; load and return-with-value decode on bits 11:10,
   // sub and add on bits 11:9, so the zero low bits stand for ignored positions
   localparam logic [3:0] LOP_LOAD = 4'h0;
   localparam logic [3:0] LOP_RETV = 4'h4;
   localparam logic [3:0] LOP_OR   = 4'h8;
   localparam logic [3:0] LOP_AND  = 4'h9;
   localparam logic [3:0] LOP_XOR  = 4'hA;
   localparam logic [3:0] LOP_SUB  = 4'hC;
   localparam logic [3:0] LOP_ADD  = 4'hE;

   // Control words in the low byte when bits 13:7 are zero
   localparam logic [7:0] CW_RETURN  = 8'h08;
   localparam logic [7:0] CW_IRQRET  = 8'h09;
   localparam logic [7:0] CW_STANDBY = 8'h63;
   localparam logic [7:0] CW_WDTCLR  = 8'h64;

   // Data addresses with special meaning
   localparam logic [6:0] A_TIMER0_COUNT   = 7'h01;
   localparam logic [6:0] A_STATUS = 7'h03;
   localparam logic [6:0] A_PORT   = 7'h05;
   localparam logic [6:0] A_UPCL   = 7'h0A;
   localparam logic [6:0] A_IRQ    = 7'h0B;

   // Field positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int IRQ_GIE = 7;
   localparam int UPCL_HI = 4;
   localparam int UPCL_LO = 3;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_PSA = 1;

   // Register port offsets and reset values
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_STATE = 4'h1;
   localparam logic [3:0] REG_PC    = 4'h2;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [12:0] PC_RESET = 13'h0000;

   // Four internal phases make one instruction cycle
   typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_EXEC, PH_NEXT} mide_phase_t;

endpackage : mide_pkg

// File: hdl/mide_alu.sv
// Combinational ALU of the instruction core: result, carry, nibble carry.
// Assumes the caller passes the literal as operand for literal-group words.
`timescale 1ns/10ps
module mide_alu (
   input  wire logic [13:0] instr,
   input  wire logic [7:0]  acc,
   input  wire logic [7:0]  opnd,
   input  wire logic        carry_in,
   output logic      [7:0]  res,
   output logic             c_out,
   output logic             dc_out
);

   logic [8:0] add9;
   logic [4:0] addn;
   logic [8:0] sub9;
   logic [4:0] subn;
   logic [7:0] mask;

   // Subtraction is operand minus accumulator; carry means no borrow
   assign add9 = {1'b0, acc} + {1'b0, opnd};
   assign addn = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
   assign sub9 = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
   assign subn = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
   assign mask = 8'h01 << instr[9:7];

   // Operation select by group and code
   always_comb
   begin
      res    = acc;
      c_out  = carry_in;
      dc_out = 1'b0;
      case (instr[13:12])
         mide_pkg::GRP_BYTE:
         begin
            case (instr[11:8])
               mide_pkg::OP_MOVWF: res = acc;
               mide_pkg::OP_CLR:   res = 8'h00;
               mide_pkg::OP_SUB:
               begin
                  {c_out, res} = sub9;
                  dc_out       = subn[4];
               end
               mide_pkg::OP_DEC:   res = opnd - 8'h01;
               mide_pkg::OP_OR:    res = acc | opnd;
               mide_pkg::OP_AND:   res = acc & opnd;
               mide_pkg::OP_XOR:   res = acc ^ opnd;
               mide_pkg::OP_ADD:
               begin
                  {c_out, res} = add9;
                  dc_out       = addn[4];
               end
               mide_pkg::OP_MOV:   res = opnd;
               mide_pkg::OP_COM:   res = ~opnd;
               mide_pkg::OP_INC:   res = opnd + 8'h01;
               mide_pkg::OP_DECSZ: res = opnd - 8'h01;
               mide_pkg::OP_RRC:   {res, c_out} = {carry_in, opnd};
               mide_pkg::OP_RLC:   {c_out, res} = {opnd, carry_in};
               mide_pkg::OP_SWAP:  res = {opnd[3:0], opnd[7:4]};
               default:            res = opnd + 8'h01;
            endcase
         end
         mide_pkg::GRP_BIT:
            res = instr[10] ? (opnd | mask) : (opnd & ~mask);
         mide_pkg::GRP_LIT:
         begin
            // Ignored code bits are never compared, so either value decodes alike
            if (instr[11:10] == mide_pkg::LOP_LOAD[3:2])
               res = opnd;
            else if (instr[11:10] == mide_pkg::LOP_RETV[3:2])
               res = opnd;
            else if (instr[11:9] == mide_pkg::LOP_SUB[3:1])
            begin
               {c_out, res} = sub9;
               dc_out       = subn[4];
            end
            else
            begin
               case (instr[11:8])
                  mide_pkg::LOP_OR:  res = acc | opnd;
                  mide_pkg::LOP_AND: res = acc & opnd;
                  mide_pkg::LOP_XOR: res = acc ^ opnd;
                  default:
                  begin
                     {c_out, res} = add9;
                     dc_out       = addn[4];
                  end
               endcase
            end
         end
         default: res = acc;
      endcase
   end

endmodule : mide_alu

// File: hdl/mide_core.sv
// Instruction decode and execute core of a small 8-bit accumulator machine.
// Assumes a program store answering prog_addr within one clock edge and
// a register port driven by a synchronous master.
//
// Overview of operation
// - Each instruction is one 14-bit word.
// - Direct register address spans 0x00 to 0x7F.
// - Target bit picks accumulator or register.
// - Position field picks one of eight bits.
// - Ignored bits never change the decoded operation.
// - One cycle; skips and branches add dummy cycle.
// - Four clock phases per instruction cycle.
// - Byte logic ops update only zero.
// - Add and subtract update carry, nibble, zero.
// - Count-and-skip ops leave flags unchanged.
// - Rotates go through carry, update carry only.
// - Bit group clears, sets, or tests-and-skips.
// - Literal holds 8-bit constant or 11-bit target.
// - Literal or/and update zero; load touches none.
// - Returns pop stack_head; irq_return sets enable.
// - return_with_value loads literal and returns.
// - Standby enters low power, updates two flags.
// - Watchdog clear op clears counter, sets flags.
// - Port read-back uses pin levels, not latch.
// - Writing timer0_count clears assigned prescaler.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module mide_core #(
   parameter int STACK_DEPTH = mide_pkg::STACK_D
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [15:0] bus_rdata,
   output logic      [12:0] prog_addr,
   input  wire logic [13:0] prog_data,
   input  wire logic [7:0]  port_pins,
   output logic      [7:0]  port_latch,
   input  wire logic        wake,
   output logic             standby,
   output logic             watchdog_clear,
   output logic             prescaler_clear
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   mide_pkg::mide_phase_t phase;
   logic [13:0]   ir;
   logic          live;
   logic          flush;
   logic [12:0]   pc;
   logic [7:0]    acc;
   logic          carry;
   logic          nibble_carry;
   logic          zero;
   logic          timeout_flag;
   logic          powerdown_flag;
   logic [1:0]    ctrl;
   logic [7:0]    opnd;
   logic [7:0]    file_q [128];
   logic [12:0]   stack [STACK_DEPTH];
   logic [SP_W-1:0] sp;

   // Decoded fields of the current word
   logic [1:0]    grp;
   logic [3:0]    op;
   logic          dest;
   logic [6:0]    faddr;
   logic [2:0]    bsel;
   logic [7:0]    lit;
   logic [10:0]   tgt;
   logic [7:0]    status_byte;
   logic [7:0]    rd_val;
   logic [12:0]   stack_head;
   logic [7:0]    res;
   logic          c_out;
   logic          dc_out;

   // Decoded operation strobes
   logic          exec;
   logic          is_byte;
   logic          is_bit;
   logic          is_lit;
   logic          is_ctrl;
   logic          is_sys;
   logic          op_call;
   logic          op_jump;
   logic          op_ret;
   logic          op_irqret;
   logic          op_retv;
   logic          op_standby;
   logic          op_wdtclr;
   logic          wr_file;
   logic          wr_acc;
   logic          upd_z;
   logic          upd_c;
   logic          upd_dc;
   logic          skip;
   logic          branch;
   logic [12:0]   target;

   // Field extraction: code, target bit, address, position, literal
   assign grp   = ir[13:12];
   assign op    = ir[11:8];
   assign dest  = ir[7];
   assign faddr = ir[6:0];
   assign bsel  = ir[9:7];
   assign lit   = ir[7:0];
   assign tgt   = ir[10:0];

   assign status_byte = {3'h0, timeout_flag, powerdown_flag, zero, nibble_carry, carry};
   assign stack_head  = stack[sp - 1'b1];
   assign target      = {file_q[mide_pkg::A_UPCL][mide_pkg::UPCL_HI:mide_pkg::UPCL_LO], tgt};

   // Group decode; don't-care bits are simply never compared
   assign exec     = (phase == mide_pkg::PH_EXEC) && live && !standby;
   assign is_byte  = grp == mide_pkg::GRP_BYTE;
   assign is_bit   = grp == mide_pkg::GRP_BIT;
   assign is_ctrl  = grp == mide_pkg::GRP_CTRL;
   assign is_lit   = grp == mide_pkg::GRP_LIT;
   assign is_sys   = is_byte && (op == mide_pkg::OP_MOVWF) && !dest;
   assign op_call  = is_ctrl && !ir[11];
   assign op_jump  = is_ctrl && ir[11];
   assign op_ret    = is_sys && (lit == mide_pkg::CW_RETURN);
   assign op_irqret = is_sys && (lit == mide_pkg::CW_IRQRET);
   assign op_standby = is_sys && (lit == mide_pkg::CW_STANDBY);
   assign op_wdtclr = is_sys && (lit == mide_pkg::CW_WDTCLR);
   assign op_retv  = is_lit && (op[3:2] == mide_pkg::LOP_RETV[3:2]);

   // Result routing: register when target bit set, else accumulator
   assign wr_file = (is_byte && dest) || (is_bit && !ir[11]);
   assign wr_acc  = (is_byte && !dest && (op != mide_pkg::OP_MOVWF)) || is_lit;

   // Flag update masks per operation
   always_comb
   begin
      upd_z  = 1'b0;
      upd_c  = 1'b0;
      upd_dc = 1'b0;
      if (is_byte)
      begin
         case (op)
            mide_pkg::OP_ADD, mide_pkg::OP_SUB:
            begin
               upd_z  = 1'b1;
               upd_c  = 1'b1;
               upd_dc = 1'b1;
            end
            mide_pkg::OP_OR, mide_pkg::OP_AND, mide_pkg::OP_XOR,
            mide_pkg::OP_CLR, mide_pkg::OP_DEC, mide_pkg::OP_MOV,
            mide_pkg::OP_COM, mide_pkg::OP_INC:
               upd_z = 1'b1;
            mide_pkg::OP_RRC, mide_pkg::OP_RLC:
               upd_c = 1'b1;
            default:
               upd_z = 1'b0;
         endcase
      end
      else if (is_lit)
      begin
         if ((op[3:1] == mide_pkg::LOP_ADD[3:1]) || (op[3:1] == mide_pkg::LOP_SUB[3:1]))
         begin
            upd_z  = 1'b1;
            upd_c  = 1'b1;
            upd_dc = 1'b1;
         end
         else if (op[3])
            upd_z = 1'b1;
      end
   end

   // Conditional skips from count-and-skip and bit tests
   always_comb
   begin
      skip = 1'b0;
      if (is_byte && ((op == mide_pkg::OP_DECSZ) || (op == mide_pkg::OP_INCSZ)))
         skip = (res == 8'h00);
      else if (is_bit && ir[11])
         skip = (opnd[bsel] == ir[10]);
   end

   assign branch = op_call || op_jump || op_ret || op_irqret || op_retv;

   // Data read path; the port address returns the pins, not the latch
   always_comb
   begin
      case (faddr)
         mide_pkg::A_PORT:   rd_val = port_pins;
         mide_pkg::A_STATUS: rd_val = status_byte;
         default:            rd_val = file_q[faddr];
      endcase
   end

   mide_alu u_alu (
      .instr    (ir),
      .acc      (acc),
      .opnd     (opnd),
      .carry_in (carry),
      .res      (res),
      .c_out    (c_out),
      .dc_out   (dc_out)
   );

   // Phase sequencer; standby freezes it in the last phase until wake
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         phase <= mide_pkg::PH_FETCH;
      else
      begin
         case (phase)
            mide_pkg::PH_FETCH:
               if (ctrl[mide_pkg::CTRL_RUN])
                  phase <= mide_pkg::PH_READ;
            mide_pkg::PH_READ:  phase <= mide_pkg::PH_EXEC;
            mide_pkg::PH_EXEC:  phase <= mide_pkg::PH_NEXT;
            mide_pkg::PH_NEXT:
               if (!standby || wake)
                  phase <= mide_pkg::PH_FETCH;
            default:            phase <= mide_pkg::PH_FETCH;
         endcase
      end
   end

   // Fetch; a flushed cycle runs as a dummy so the word is not taken
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ir    <= 14'h0000;
         live  <= 1'b0;
         flush <= 1'b0;
      end
      else if (phase == mide_pkg::PH_FETCH && ctrl[mide_pkg::CTRL_RUN])
      begin
         live  <= !flush;
         flush <= 1'b0;
         if (!flush)
            ir <= prog_data;
      end
      else if (exec && (skip || branch))
         flush <= 1'b1;
   end

   // Program counter: step, skip over next word, branch or return
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pc <= mide_pkg::PC_RESET;
      else if (phase == mide_pkg::PH_FETCH && ctrl[mide_pkg::CTRL_RUN] && !flush)
         pc <= pc + 13'h0001;
      else if (exec)
      begin
         if (op_call || op_jump)
            pc <= target;
         else if (op_ret || op_irqret || op_retv)
            pc <= stack_head;
         else if (skip)
            pc <= pc + 13'h0001;
      end
   end

   // Program address registered once per cycle from the counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prog_addr <= mide_pkg::PC_RESET;
      else if (phase == mide_pkg::PH_NEXT)
         prog_addr <= pc;
   end

   // Return stack; circular, so overflow silently overwrites the oldest
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sp <= '0;
      else if (exec && op_call)
         sp <= sp + 1'b1;
      else if (exec && (op_ret || op_irqret || op_retv))
         sp <= sp - 1'b1;
   end

   for (genvar i = 0; i < STACK_DEPTH; i++)
   begin : g_stack
      always_ff @(posedge clk)
      begin
         if (!rst_n)
            stack[i] <= 13'h0000;
         else if (exec && op_call && (sp == SP_W'(i)))
            stack[i] <= pc;
      end
   end

   // Operand capture in the read phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         opnd <= 8'h00;
      else if (phase == mide_pkg::PH_READ)
         opnd <= is_lit ? lit : rd_val;
   end

   // Accumulator
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         acc <= 8'h00;
      else if (exec && wr_acc)
         acc <= res;
   end

   // Data register file; irq_return also raises the global enable
   for (genvar j = 0; j < 128; j++)
   begin : g_file
      always_ff @(posedge clk)
      begin
         if (!rst_n)
            file_q[j] <= 8'h00;
         else if (exec && wr_file && (faddr == 7'(j)))
            file_q[j] <= res;
         else if (exec && op_irqret && (j == 32'(mide_pkg::A_IRQ)))
            file_q[j][mide_pkg::IRQ_GIE] <= 1'b1;
      end
   end

   assign port_latch = file_q[mide_pkg::A_PORT];

   // Arithmetic flags; a direct status write is overridden by updates
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         carry        <= 1'b0;
         nibble_carry <= 1'b0;
         zero         <= 1'b0;
      end
      else if (exec)
      begin
         if (wr_file && (faddr == mide_pkg::A_STATUS))
         begin
            carry        <= res[mide_pkg::ST_C];
            nibble_carry <= res[mide_pkg::ST_DC];
            zero         <= res[mide_pkg::ST_Z];
         end
         if (upd_c)
            carry <= c_out;
         if (upd_dc)
            nibble_carry <= dc_out;
         if (upd_z)
            zero <= (res == 8'h00);
      end
   end

   // Power flags: both set at power-up, standby clears powerdown
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b1;
      end
      else if (exec && op_standby)
      begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b0;
      end
      else if (exec && op_wdtclr)
      begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b1;
      end
   end

   // Standby holds until wake; wake is only seen in the frozen phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         standby <= 1'b0;
      else if (exec && op_standby)
         standby <= 1'b1;
      else if (wake)
         standby <= 1'b0;
   end

   // One-cycle side-effect pulses toward watchdog and prescaler
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         watchdog_clear  <= 1'b0;
         prescaler_clear <= 1'b0;
      end
      else
      begin
         watchdog_clear  <= exec && (op_wdtclr || op_standby);
         prescaler_clear <= exec && wr_file && (faddr == mide_pkg::A_TIMER0_COUNT)
                            && ctrl[mide_pkg::CTRL_PSA];
      end
   end

   // Control register written over the register port
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ctrl <= mide_pkg::CTRL_RESET;
      else if (bus_wr && (bus_addr == mide_pkg::REG_CTRL))
         ctrl <= bus_wdata[1:0];
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         bus_rdata <= 16'h0000;
      else if (bus_rd)
      begin
         case (bus_addr)
            mide_pkg::REG_CTRL:  bus_rdata <= {14'h0000, ctrl};
            mide_pkg::REG_STATE: bus_rdata <= {status_byte, acc};
            mide_pkg::REG_PC:    bus_rdata <= {3'h0, pc};
            default:             bus_rdata <= 16'h0000;
         endcase
      end
      else
         bus_rdata <= 16'h0000;
   end

endmodule : mide_core

// File: sim/mide_core_props.sv
// Port-level checker for the instruction core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module mide_props (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        bus_rd,
   input wire logic [15:0] bus_rdata,
   input wire logic [12:0] prog_addr,
   input wire logic [7:0]  port_latch,
   input wire logic        wake,
   input wire logic        standby,
   input wire logic        watchdog_clear,
   input wire logic        prescaler_clear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Read data is zero outside the answer cycle
   a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000) else $error("rdata not idle");
   a_wdc_one_cycle: assert property (watchdog_clear |=> !watchdog_clear) else $error("wdc pulse long");
   a_psc_one_cycle: assert property (prescaler_clear |=> !prescaler_clear) else $error("psc pulse long");
   // One program address per four-phase cycle
   a_pc_stands: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3]) else $error("pc short");
   a_standby_hold: assert property (standby && !wake |=> standby) else $error("standby dropped");
   // The address of the word after standby still lands one edge after entry
   a_standby_frz: assert property (standby && $past(standby, 2) |-> $stable(prog_addr)) else $error("pc ran");
   // Results land in EXEC, never on the address edge
   a_latch_exec: assert property ($changed(port_latch) |-> $stable(prog_addr)) else $error("latch phase");
   a_start_zero: assert property ($rose(rst_n) |-> prog_addr == 13'h0000) else $error("pc reset");
endmodule : mide_props
bind mide_core mide_props u_props (
   .clk(clk), .rst_n(rst_n), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .prog_addr(prog_addr),
   .port_latch(port_latch), .wake(wake), .standby(standby), .watchdog_clear(watchdog_clear),
   .prescaler_clear(prescaler_clear));

// File: sim/tb_top.sv
// Self-checking bench: runs a short program, then checks results over the register port.
// Assumes the program store answers prog_addr combinationally.
`timescale 1ns/10ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  bus_addr = 4'h0;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [7:0]  port_pins = 8'hA5;
   logic        wake = 1'b0;
   logic [15:0] bus_rdata;
   logic [12:0] prog_addr;
   logic [13:0] prog_data;
   logic [7:0]  port_latch;
   logic        standby, watchdog_clear, prescaler_clear;
   logic [13:0] rom [0:31];
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n_wdc = 0;
   int          n_psc = 0;
   // Part 1: load, add literal, watchdog clear, read pins, standby.
   // Part 2: latch and timer writes, call/return with value, bit skip, subtract, rotate, standby.
   // Part 3: count-and-skip, bit set, move, watchdog clear, jump to self; subroutine at 1E
   initial rom = '{14'h303C, 14'h3EC4, 14'h0064, 14'h0805, 14'h0063, 14'h3081, 14'h0085, 14'h0081,
                   14'h201E, 14'h1C05, 14'h30FF, 14'h3C40, 14'h0C05, 14'h0063, 14'h3001, 14'h00A0,
                   14'h0BA0, 14'h30FF, 14'h17A0, 14'h0820, 14'h0064, 14'h2815, 14'h0000, 14'h0000,
                   14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h3442, 14'h0000};
   assign prog_data = rom[prog_addr[4:0]];
   mide_core DUT (
      .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .prog_addr(prog_addr), .prog_data(prog_data),
      .port_pins(port_pins), .port_latch(port_latch), .wake(wake), .standby(standby),
      .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear));
   initial forever #25 clk = ~clk;
   // Cycle counter bounds the run; also counts watchdog pulses
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (watchdog_clear === 1'b1) n_wdc <= n_wdc + 1;
      if (prescaler_clear === 1'b1) n_psc <= n_psc + 1;
      if (cyc == 2000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task automatic bus_read(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 chk16(bus_rdata, exp);
   endtask : bus_read
   task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : bus_write
   // Pulse wake, then let standby fall so a following wait sees the next entry only
   task automatic wake_core();
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      wait (standby === 1'b0);
   endtask : wake_core
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // Main sequence; the program parks in standby at the first two checkpoints and in a jump to self at the last, so reads see settled state
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait (standby === 1'b1);
      bus_read(mide_pkg::REG_STATE, 16'h13A5);
      chk16({15'h0000, standby}, 16'h0001);
      chk16({8'h00, port_latch}, 16'h0000);
      bus_write(mide_pkg::REG_CTRL, 16'h0003);
      bus_read(mide_pkg::REG_CTRL, 16'h0003);
      wake_core();
      wait (standby === 1'b1);
      bus_read(mide_pkg::REG_STATE, 16'h1152);
      chk16({8'h00, port_latch}, 16'h0081);
      chk16(16'(n_psc), 16'h0001);
      wake_core();
      repeat (60) @(posedge clk);
      bus_read(mide_pkg::REG_STATE, 16'h1980);
      bus_write(mide_pkg::REG_STATE, 16'h0000);
      bus_read(mide_pkg::REG_STATE, 16'h1980);
      bus_read(4'hF, 16'h0000);
      chk16(16'(n_wdc), 16'h0004);
      chk16({15'h0000, standby}, 16'h0000);
      chk16({3'h0, prog_addr}, 16'h0015);
      stop_test();
   end
endmodule : tb_top
